// [ebal_map.svh]
`ifndef EBAL_MAP_SVH
`define EBAL_MAP_SVH
// width/halted code values
`define EBAL_CODE_W8 2'h0
`define EBAL_CODE_W16 2'h1
`define EBAL_CODE_W32 2'h2
`define EBAL_CODE_HALT 2'h3
// idle levels driven in reset and halt; the low address bits take theirs in reset only
`define EBAL_ALE_IDLE 1'h0
`define EBAL_ADS_IDLE 1'h1
`define EBAL_BE_IDLE 4'hf
`define EBAL_LOW_RST 2'h0
`endif

// [ebal_pkg.sv]
package ebal_pkg;
  typedef enum logic [1:0] {
    EBAL_W8 = 2'h0,
    EBAL_W16 = 2'h1,
    EBAL_W32 = 2'h2
  } ebal_width_t;
  typedef enum logic [3:0] {
    EBAL_IDLE = 4'h1,
    EBAL_ADDR = 4'h2,
    EBAL_DATA = 4'h4,
    EBAL_HALT = 4'h8
  } ebal_state_t;
endpackage : ebal_pkg

// [ebal_lane_dec.sv]
`timescale 1ns/100ps
`include "ebal_map.svh"
// lane decoder: maps width, byte address and byte mask onto the lane pins
module ebal_lane_dec
  import ebal_pkg::*;
(
  // request
  input wire ebal_width_t i_width,
  input wire logic [3:0] i_addr,
  input wire logic [3:0] i_mask,
  // lane pins
  output logic [1:0] o_low_bits,
  output logic [3:0] o_be_n
);
  wire [3:0] mask_n = ~i_mask;
  // shared byte-enable layout per width
  assign o_be_n = (i_width == EBAL_W32) ? mask_n : // see RULE_07
                  (i_width == EBAL_W16) ? {mask_n[1], 1'b1, i_addr[1], mask_n[0]} : // see RULE_08
                  {2'b11, i_addr[1], i_addr[0]}; // see RULE_09 see RULE_10
  assign o_low_bits = i_addr[3:2];
endmodule : ebal_lane_dec

// [ebal_addr_lane.sv]
// Operation
// RULE_01 - inverted latch output is always the complement of the latch strobe
// RULE_02 - address strobe low for the whole address cycle of each access
// RULE_03 - outside logic samples address strobe at end of address cycle
// RULE_04 - 32-bit region: drive address bits 3:2, step word address per ready
// RULE_05 - 16-bit region: bits 3:1, bit 1 on lane 1, step halfword per ready
// RULE_06 - 8-bit region: bits 3:0, bits 1:0 on lanes 1:0, step byte
// RULE_07 - 32-bit region: lanes 3..0 qualify bytes 31:24 down to 7:0
// RULE_08 - 16-bit region: lane3 high byte, lane2 high, lane1 addr bit1, lane0 low
// RULE_09 - 8-bit region: lane3 high, lane1 address bit1, lane0 address bit0
// RULE_10 - 8-bit region: lane 2 held high and unused
// RULE_11 - byte enables fixed from address cycle through last data cycle
// RULE_12 - unaligned requests split into transactions with fixed enables
// RULE_13 - width code 00 8-bit, 01 16-bit, 10 32-bit, 11 halted
// RULE_14 - width code floats whenever the bus is given up for hold
// RULE_15 - hold floats strobes, bits, enables; reset/halt drive them high (code resets the low address bits to 0 and keeps the last ones in halt)
// RULE_16 - outside logic withholds ready for wait; each ready advances burst
`timescale 1ns/100ps
`include "ebal_map.svh"
module ebal_addr_lane
  import ebal_pkg::*;
#(
  parameter int BEATS_W = 3
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // processor side request
  input wire logic i_req_valid,
  input wire ebal_width_t i_req_width,
  input wire logic [3:0] i_req_addr,
  input wire logic [3:0] i_req_mask,
  input wire logic [BEATS_W-1:0] i_req_beats,
  input wire logic i_halt,
  input wire logic i_hold,
  // bus handshake
  input wire logic i_ready_recover_n,
  // request accepted pulse and done pulse
  output logic o_req_taken,
  output logic o_xfer_done,
  // bus pins
  output logic o_ale,
  output logic o_ale_n,
  output logic o_address_strobe_n,
  output logic [1:0] o_low_address_bits,
  output logic [3:0] o_byte_lane_enables,
  output logic [1:0] o_width_halt_code,
  output logic o_ctl_oe,
  output logic o_code_oe
);
  // transaction context and the decoder's view of it
  ebal_state_t state_reg, state_next;
  ebal_width_t width_reg;
  logic [3:0] addr_reg, mask_reg;
  logic [BEATS_W-1:0] beats_reg;
  logic [1:0] low_bits;
  logic [3:0] be_n;

  // address step in bytes for the region width
  function automatic logic [3:0] ebal_step(input ebal_width_t w);
    ebal_step = (w == EBAL_W32) ? 4'h4 : (w == EBAL_W16) ? 4'h2 : 4'h1;
  endfunction : ebal_step

  // requests must already be aligned pieces; unaligned ones split upstream
  wire take = (state_reg == EBAL_IDLE) && i_req_valid && !i_hold && !i_halt; // see RULE_12
  wire ready = (state_reg == EBAL_DATA) && !i_ready_recover_n; // see RULE_16
  wire last = ready && (beats_reg == '0);

  // halt only from idle; hold wins so the bus can be handed over from halt
  wire halt_go = i_halt && !i_hold;
  wire halt_leave = !i_halt || i_hold;

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EBAL_IDLE: begin
        if (halt_go) begin
          state_next = EBAL_HALT;
        end else if (take) begin
          state_next = EBAL_ADDR;
        end
      end
      EBAL_ADDR: begin
        state_next = EBAL_DATA; // exactly one address cycle
      end
      EBAL_DATA: begin
        if (last) begin
          state_next = EBAL_IDLE;
        end
      end
      EBAL_HALT: begin
        if (halt_leave) begin
          state_next = EBAL_IDLE;
        end
      end
      default: begin
        state_next = EBAL_IDLE; // stray code
      end
    endcase
  end

  // decoder sees the held context, so it gives the lanes of the running beat
  ebal_lane_dec u_dec (
    .i_width(width_reg),
    .i_addr(addr_reg),
    .i_mask(mask_reg),
    .o_low_bits(low_bits),
    .o_be_n(be_n)
  );

  // one beat advances when ready lands and more beats remain
  wire step = ready && !last; // see RULE_16
  wire [3:0] step_addr = 4'(addr_reg + ebal_step(width_reg)); // see RULE_04 see RULE_05 see RULE_06
  wire [BEATS_W-1:0] beats_left = BEATS_W'(beats_reg - 1'b1);

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= EBAL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // transaction context; byte mask frozen for the whole transaction
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      width_reg <= EBAL_W32;
      addr_reg <= 4'h0;
      mask_reg <= 4'h0;
      beats_reg <= '0;
    end else if (take) begin
      width_reg <= i_req_width;
      addr_reg <= i_req_addr;
      mask_reg <= i_req_mask; // see RULE_11
      beats_reg <= i_req_beats;
    end else if (step) begin
      addr_reg <= step_addr;
      beats_reg <= beats_left;
    end
  end

  // pins are registered, so they are built from what the context holds next cycle
  wire next_addr = (state_next == EBAL_ADDR);
  wire next_data = (state_next == EBAL_DATA);
  wire next_busy = next_addr || next_data;
  wire next_halt = (state_next == EBAL_HALT);
  wire [3:0] addr_nx = take ? i_req_addr : step ? step_addr : addr_reg;
  wire [1:0] width_nx = take ? i_req_width : width_reg;

  // lanes of a fresh request; same layout as the decoder, one cycle earlier
  wire [3:0] req_mask_n = ~i_req_mask;
  wire [3:0] req_be_w32 = req_mask_n; // see RULE_07
  wire [3:0] req_be_w16 = {req_mask_n[1], 1'b1, i_req_addr[1], req_mask_n[0]}; // see RULE_08
  wire [3:0] req_be_w8 = {2'b11, i_req_addr[1:0]}; // see RULE_09 see RULE_10
  wire [3:0] req_be = (i_req_width == EBAL_W32) ? req_be_w32 :
                      (i_req_width == EBAL_W16) ? req_be_w16 : req_be_w8;

  // lanes of a running burst: enable roles hold, address roles follow the step
  wire [3:0] run_be_w32 = be_n; // see RULE_07
  wire [3:0] run_be_w16 = {be_n[3:2], addr_nx[1], be_n[0]}; // see RULE_05
  wire [3:0] run_be_w8 = {be_n[3:2], addr_nx[1:0]}; // see RULE_06
  wire [3:0] run_be = (width_reg == EBAL_W32) ? run_be_w32 :
                      (width_reg == EBAL_W16) ? run_be_w16 : run_be_w8;
  wire [3:0] be_nx = take ? req_be : run_be; // see RULE_11

  // parked values while idle, halted or in reset
  wire [3:0] be_pin_nx = next_busy ? be_nx : `EBAL_BE_IDLE; // see RULE_15
  wire [1:0] low_pin_nx = next_busy ? addr_nx[3:2] : low_bits;
  wire [1:0] code_pin_nx = next_halt ? `EBAL_CODE_HALT : width_nx; // see RULE_13
  // pins given up only between transfers; a burst under way is finished first
  wire drive_nx = !(i_hold && !next_busy); // see RULE_14 see RULE_15

  // latch strobe pair and address strobe mark exactly the address cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ale <= `EBAL_ALE_IDLE;
      o_ale_n <= ~`EBAL_ALE_IDLE;
      o_address_strobe_n <= `EBAL_ADS_IDLE;
    end else begin
      o_ale <= next_addr;
      o_ale_n <= ~next_addr; // see RULE_01
      o_address_strobe_n <= ~next_addr; // see RULE_02
    end
  end

  // partial address and byte lanes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_low_address_bits <= `EBAL_LOW_RST;
      o_byte_lane_enables <= `EBAL_BE_IDLE;
    end else begin
      o_low_address_bits <= low_pin_nx; // see RULE_04
      o_byte_lane_enables <= be_pin_nx; // see RULE_11
    end
  end

  // width or halted code
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_width_halt_code <= `EBAL_CODE_HALT;
    end else begin
      o_width_halt_code <= code_pin_nx;
    end
  end

  // output enables; they drop in hold so the pins float outside
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctl_oe <= 1'b1;
      o_code_oe <= 1'b1;
    end else begin
      o_ctl_oe <= drive_nx; // see RULE_15
      o_code_oe <= drive_nx; // see RULE_14
    end
  end

  // status pulses for the requester
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req_taken <= 1'b0;
      o_xfer_done <= 1'b0;
    end else begin
      o_req_taken <= take;
      o_xfer_done <= last;
    end
  end
endmodule : ebal_addr_lane

// [ebal_rdy_model.sv]
`timescale 1ns/100ps
// far side: answers each beat after a set number of wait cycles
module ebal_rdy_model (
  input wire logic i_ref_clk, i_rst, i_ads_n,
  input wire logic [1:0] i_wait,
  input wire logic [2:0] i_beats,
  output logic o_ready_recover_n
);
  logic act_reg;
  logic [1:0] cnt_reg;
  logic [2:0] left_reg;
  // address strobe seen low at end of address cycle starts the data cycles
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      act_reg <= 1'h0;
      cnt_reg <= 2'h0;
      left_reg <= 3'h0;
    end else if (!i_ads_n) begin
      act_reg <= 1'h1;
      cnt_reg <= 2'h0;
      left_reg <= i_beats;
    end else if (act_reg && cnt_reg == i_wait) begin
      cnt_reg <= 2'h0;
      left_reg <= left_reg - 3'h1;
      act_reg <= left_reg != 3'h0;
    end else if (act_reg) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  // ready withheld for wait cycles, idle high outside data cycles
  assign o_ready_recover_n = !(act_reg && cnt_reg == i_wait);
endmodule : ebal_rdy_model

// [ebal_addr_lane_checker.sv]
`timescale 1ns/100ps
module ebal_addr_lane_checker
  import ebal_pkg::*;
(
  input wire logic i_ref_clk, i_rst, i_halt, i_hold, i_ready_recover_n,
  input wire ebal_width_t i_req_width,
  input wire logic o_req_taken, o_xfer_done, o_ale, o_ale_n, o_address_strobe_n, o_ctl_oe, o_code_oe,
  input wire logic [1:0] o_low_address_bits, o_width_halt_code,
  input wire logic [3:0] o_byte_lane_enables
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_aln; o_ale_n == !o_ale; endproperty
  a_aln: assert property (p_aln) else $error("latch pair not complementary");
  property p_ads; o_req_taken |-> !o_address_strobe_n && o_ale ##1 o_address_strobe_n; endproperty
  a_ads: assert property (p_ads) else $error("address strobe wrong");
  property p_code; o_req_taken |-> o_width_halt_code == $past(i_req_width); endproperty
  a_code: assert property (p_code) else $error("width code wrong");
  // enable roles must not move while a burst runs; address roles on lanes 1:0 step
  property p_lane; o_ale |=> ($stable(o_width_halt_code) && $stable(o_byte_lane_enables[3:2])
    && (o_width_halt_code == 2'h0 || $stable(o_byte_lane_enables[0]))
    && (o_width_halt_code != 2'h2 || $stable(o_byte_lane_enables[1]))) until o_xfer_done; endproperty
  a_lane: assert property (p_lane) else $error("lanes moved in burst");
  property p_done; o_ale |-> ##[2:60] o_xfer_done; endproperty
  a_done: assert property (p_done) else $error("transfer never ended");
  property p_step; !i_ready_recover_n && !o_ale && o_width_halt_code == 2'h2
    |=> o_xfer_done || o_low_address_bits == $past(o_low_address_bits) + 2'h1; endproperty
  a_step: assert property (p_step) else $error("word address not stepped");
  property p_step16; !i_ready_recover_n && !o_ale && o_width_halt_code == 2'h1
    |=> o_xfer_done || {o_low_address_bits, o_byte_lane_enables[1]}
      == $past({o_low_address_bits, o_byte_lane_enables[1]}) + 3'h1; endproperty
  a_step16: assert property (p_step16) else $error("halfword address not stepped");
  property p_step8; !i_ready_recover_n && !o_ale && o_width_halt_code == 2'h0
    |=> o_xfer_done || {o_low_address_bits, o_byte_lane_enables[1:0]}
      == $past({o_low_address_bits, o_byte_lane_enables[1:0]}) + 4'h1; endproperty
  a_step8: assert property (p_step8) else $error("byte address not stepped");
  property p_halt; (i_halt && !i_hold && o_address_strobe_n && o_byte_lane_enables == 4'hf)[*3]
    |-> o_width_halt_code == 2'h3; endproperty
  a_halt: assert property (p_halt) else $error("halt code missing");
  property p_hold; i_hold[*8] |-> !o_code_oe && !o_ctl_oe; endproperty
  a_hold: assert property (p_hold) else $error("pins driven in hold");
endmodule : ebal_addr_lane_checker
bind ebal_addr_lane ebal_addr_lane_checker u_chk (.*);

// [ebal_addr_lane_tb.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("Error %0t %h %h", $time, a, b); end end
module ebal_addr_lane_tb;
  import ebal_pkg::*;
  logic clk = 0, rst = 1, vld = 0, halt = 0, hold = 0, rdy_n, tk, dn, ale, ale_n, ads_n, coe, oe;
  ebal_width_t wd = EBAL_W8;
  logic [3:0] ad = 4'h0, mk = 4'h0, be;
  logic [2:0] bt = 3'h0;
  logic [1:0] wt = 2'h0, lo, cd;
  int compares = 0, miscompares = 0;
  ebal_addr_lane dut (.i_ref_clk(clk), .i_rst(rst), .i_req_valid(vld), .i_req_width(wd), .i_req_addr(ad),
    .i_req_mask(mk), .i_req_beats(bt), .i_halt(halt), .i_hold(hold), .i_ready_recover_n(rdy_n),
    .o_req_taken(tk), .o_xfer_done(dn), .o_ale(ale), .o_ale_n(ale_n), .o_address_strobe_n(ads_n),
    .o_low_address_bits(lo), .o_byte_lane_enables(be), .o_width_halt_code(cd), .o_ctl_oe(oe), .o_code_oe(coe));
  ebal_rdy_model u_far (.i_ref_clk(clk), .i_rst(rst), .i_ads_n(ads_n), .i_wait(wt), .i_beats(bt),
    .o_ready_recover_n(rdy_n));
  initial begin
    forever #5 clk = ~clk;
  end
  task stop_test;
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // inputs move 1 ns after the edge so sampling never races
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // one transfer: e is the expected lane pattern for the first beat
  task go(input ebal_width_t w, input logic [3:0] a, m, e, input logic [2:0] b, input logic [1:0] x);
    wd = w; ad = a; mk = m; bt = b; wt = x; vld = 1;
    for (int i = 0; i < 20 && tk !== 1'b1; i++) cyc(1);
    `CHK(tk, 1'b1)
    if (tk !== 1'b1) stop_test;
    cyc(0);
    vld = 0;
    `CHK({ale, ale_n, ads_n, coe, oe, cd, lo, be}, {3'h4, 2'h3, w, a[3:2], e})
    for (int i = 0; i < 99 && dn !== 1'b1; i++) cyc(1);
    `CHK({dn, be}, 5'h1f)
    if (dn !== 1'b1) stop_test;
  endtask : go
  task t_w32; go(EBAL_W32, 4'h4, 4'h5, 4'ha, 3'h3, 2'h1); endtask : t_w32
  task t_w16; go(EBAL_W16, 4'h6, 4'h2, 4'h7, 3'h1, 2'h0); endtask : t_w16
  task t_w8; go(EBAL_W8, 4'h9, 4'h0, 4'hd, 3'h2, 2'h2); endtask : t_w8
  // request held back while halted, then served
  task t_halt;
    halt = 1; vld = 1; wd = EBAL_W32;
    cyc(5);
    `CHK({tk, cd, be, ads_n}, 8'h7f)
    halt = 0;
    go(EBAL_W32, 4'hc, 4'hf, 4'h0, 3'h0, 2'h0);
  endtask : t_halt
  // request left waiting while the bus is handed over, then served
  task t_hold;
    hold = 1; vld = 1; wd = EBAL_W16;
    cyc(9);
    `CHK({coe, oe, tk}, 3'h0)
    hold = 0;
    go(EBAL_W16, 4'h2, 4'h3, 4'h6, 3'h0, 2'h3);
  endtask : t_hold
  initial begin
    cyc(6);
    rst = 0;
    t_w32(); t_w16(); t_w8(); t_halt(); t_hold(); t_w32();
    stop_test();
  end
endmodule : ebal_addr_lane_tb
